// file: rtl/cfp_core_fetch.sv
// Purpose: instruction fetch, pipeline control and table access of an 8-bit core
// Assumes: program and data memory run on ref_clk and answer within one phase
// Notes: one instruction cycle is four ref_clk cycles, phase strobes one-hot
// Operation
// - input clock divided by four into four non-overlapping phases.
// - program counter advances in phase one; fetched word captured in phase four.
// - cycle spans four phases; fetch of next overlaps execute of current.
// - holding register loaded in phase one, executed in phases two to four.
// - data operand read in phase two, destination written in phase four.
// - program counter changes cost two cycles by discarding fetched word.
// - byte addressed program memory, counter steps by two, bit zero zero.
// - two or four byte instructions; second word fetched the next cycle.
// - absolute call and jump word address goes to counter bits 20:1.
// - relative offset counts words, so byte displacement is twice it.
// - four two-word instructions; second word tagged 1111, twelve literal bits.
// - tagged word alone is no-operation; after its first word it is consumed.
// - working register added to counter low byte advances that many bytes, odd counts rounded down.
// - return with literal returns to caller and loads the 8-bit literal.
// - table read fetches one byte at the byte pointer into the latch.
// - table pointer addresses each byte, odd addresses included.
// - call increments stack index, then writes return address to new entry.
// - return loads counter from indexed entry, then decrements the index.
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_core_fetch #(
	parameter int STACK_DEPTH = `CFP_STACK_DEPTH,
	parameter int STACK_IDX_W = `CFP_STACK_IDX_W
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	output logic      [`CFP_PC_W-1:0]         prog_addr,
	output logic                              prog_rd,
	input  wire logic [15:0]                  prog_data,
	output logic      [11:0]                  data_addr,
	output logic                              data_rd,
	output logic                              data_wr,
	output logic      [7:0]                   data_wdata,
	input  wire logic [7:0]                   data_rdata,
	output logic      [`CFP_PHASES-1:0]       phase,
	output logic      [15:0]                  instruction_holding_register,
	output logic                              exec_valid,
	output logic      [7:0]                   working_register,
	output logic      [`CFP_PC_W-1:0]         table_byte_pointer,
	output logic      [7:0]                   table_data_latch,
	output logic      [12*`CFP_INDEX_COUNT-1:0] index_pointer,
	output logic      [STACK_IDX_W-1:0]       return_stack_index
);
	import cfp_pkg::*;

	localparam logic [STACK_IDX_W-1:0] STACK_TOP = STACK_IDX_W'(STACK_DEPTH);

	logic                  phase_one;
	logic                  phase_two;
	logic                  phase_three;
	logic                  phase_four;
	logic [`CFP_PC_W-1:0]  pc;
	logic [`CFP_PC_W-1:0]  fetch_addr;
	logic [`CFP_PC_W-1:0]  ex_addr;
	logic [15:0]           fetch_word;
	logic [15:0]           held_first;
	logic                  fetch_valid;
	logic                  second_expected;
	logic                  second_valid;
	logic                  table_pending;
	logic                  table_post_inc;
	logic [7:0]            operand;
	cfp_op_t               op_ex;
	cfp_op_t               op_load;
	logic [`CFP_PC_W-1:0]  seq_pc;
	logic [`CFP_PC_W-1:0]  rel_target;
	logic [`CFP_PC_W-1:0]  abs_target;
	logic [7:0]            pc_low_sum;
	logic [`CFP_PC_W-1:0]  stack_read_data;
	logic                  br_taken;
	logic [`CFP_PC_W-1:0]  br_target;
	logic                  consume;
	logic                  skip_next;
	logic                  push;
	logic                  pop;
	logic                  flush;
	logic                  stack_we;
	logic                  load_reads;
	logic [11:0]           load_addr;
	logic                  move_second;

	function automatic logic is_second_word(input logic [15:0] w);
		is_second_word = (w[15:12] == `CFP_NIB_SECOND);
	endfunction

	function automatic cfp_op_t decode_word(input logic [15:0] w, input logic second);
		decode_word = cfp_op_nop;
		if (is_second_word(w)) begin
			decode_word = second ? cfp_op_second : cfp_op_nop;
		end else if (w[15:12] == `CFP_NIB_BRANCH) begin
			decode_word = cfp_op_branch;
		end else if (w[15:12] == `CFP_NIB_MOVE) begin
			decode_word = cfp_op_move;
		end else if (w[15:8] == `CFP_OPC_GOTO) begin
			decode_word = cfp_op_goto;
		end else if (w[15:8] == `CFP_OPC_CALL) begin
			decode_word = cfp_op_call;
		end else if (w[15:8] == `CFP_OPC_INDEX) begin
			decode_word = cfp_op_index;
		end else if (w[15:8] == `CFP_OPC_ADD_FILE) begin
			decode_word = cfp_op_add_file;
		end else if (w[15:8] == `CFP_OPC_ADD_W) begin
			decode_word = cfp_op_add_w;
		end else if (w[15:8] == `CFP_OPC_RET_LIT) begin
			decode_word = cfp_op_ret_lit;
		end else if (w[15:8] == `CFP_OPC_LOAD_W) begin
			decode_word = cfp_op_load_w;
		end else if (w[15:8] == `CFP_OPC_TEST_SKIP) begin
			decode_word = cfp_op_test_skip;
		end else if (w[15:8] == `CFP_OPC_TPTR_LO) begin
			decode_word = cfp_op_tptr_lo;
		end else if (w[15:8] == `CFP_OPC_TPTR_HI) begin
			decode_word = cfp_op_tptr_hi;
		end else if (w[15:8] == `CFP_OPC_TPTR_UP) begin
			decode_word = cfp_op_tptr_up;
		end else if (w == `CFP_WORD_RETURN) begin
			decode_word = cfp_op_return;
		end else if (w == `CFP_WORD_TABLE_RD) begin
			decode_word = cfp_op_table_rd;
		end else if (w == `CFP_WORD_TABLE_INC) begin
			decode_word = cfp_op_table_inc;
		end
	endfunction

	cfp_phase_gen u_phase (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.phase   (phase)
	);

	assign phase_one   = phase[0];
	assign phase_two   = phase[1];
	assign phase_three = phase[2];
	assign phase_four  = phase[3];

	cfp_return_stack #(
		.DEPTH (STACK_DEPTH),
		.IDX_W (STACK_IDX_W),
		.W     (`CFP_PC_W)
	) u_stack (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.write_en   (stack_we),
		.write_idx  (return_stack_index + 1'b1),
		.write_data (seq_pc + `CFP_PC_STEP),
		.read_idx   (return_stack_index),
		.read_data  (stack_read_data)
	);

	assign op_ex   = exec_valid ? decode_word(instruction_holding_register, second_valid)
	                            : cfp_op_nop;
	assign op_load = decode_word(fetch_word, second_expected);

	assign seq_pc     = ex_addr + `CFP_PC_STEP;
	assign rel_target = seq_pc + {{9{instruction_holding_register[10]}},
	                              instruction_holding_register[10:0], 1'b0};
	assign abs_target = {prog_data[11:0], instruction_holding_register[7:0], 1'b0};
	assign pc_low_sum = seq_pc[7:0] + working_register;

	// branch decisions are taken at the phase four edge
	always_comb begin
		br_taken  = 1'b0;
		br_target = pc;
		consume   = 1'b0;
		skip_next = 1'b0;
		push      = 1'b0;
		pop       = 1'b0;
		unique case (op_ex)
			cfp_op_goto, cfp_op_call: begin
				// second word arrives in this very phase, so no extra cycle
				if (is_second_word(prog_data)) begin
					br_taken  = 1'b1;
					br_target = abs_target;
					consume   = 1'b1;
					push      = (op_ex == cfp_op_call);
				end
			end
			cfp_op_branch: begin
				br_taken  = 1'b1;
				br_target = rel_target;
			end
			cfp_op_add_file: begin
				if (instruction_holding_register[7:0] == `CFP_PC_LOW_ADDR) begin
					br_taken = 1'b1;
					// odd offsets are truncated to keep word alignment
					br_target = {seq_pc[20:8], pc_low_sum[7:1], 1'b0};
				end
			end
			cfp_op_ret_lit, cfp_op_return: begin
				br_taken  = 1'b1;
				br_target = stack_read_data;
				pop       = 1'b1;
			end
			cfp_op_test_skip: begin
				skip_next = (operand == 8'h00);
			end
			cfp_op_nop, cfp_op_move, cfp_op_index, cfp_op_second, cfp_op_add_w,
			cfp_op_load_w, cfp_op_table_rd, cfp_op_table_inc, cfp_op_tptr_lo,
			cfp_op_tptr_hi, cfp_op_tptr_up: begin
			end
		endcase
	end

	assign flush    = br_taken | skip_next | consume;
	assign stack_we = phase_four & push & (return_stack_index != STACK_TOP);

	assign load_reads = fetch_valid & ~table_pending &
	                    ((op_load == cfp_op_add_file &&
	                      fetch_word[7:0] != `CFP_PC_LOW_ADDR) ||
	                     op_load == cfp_op_add_w || op_load == cfp_op_test_skip ||
	                     op_load == cfp_op_move);
	assign load_addr  = (op_load == cfp_op_move) ? fetch_word[11:0]
	                                             : {`CFP_FILE_BANK, fetch_word[7:0]};
	assign move_second = (op_ex == cfp_op_second) &&
	                     (held_first[15:12] == `CFP_NIB_MOVE);

	// program counter and program memory address
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc         <= `CFP_RESET_PC;
			prog_addr  <= `CFP_RESET_PC;
			fetch_addr <= `CFP_RESET_PC;
			prog_rd    <= 1'b0;
		end else begin
			if (phase_one) begin
				prog_rd <= 1'b1;
				if (table_pending) begin
					prog_addr <= {table_byte_pointer[20:1], 1'b0};
				end else begin
					prog_addr  <= pc;
					fetch_addr <= pc;
					pc         <= pc + `CFP_PC_STEP;
				end
			end
			if (phase_four) begin
				prog_rd <= 1'b0;
				if (br_taken) begin
					pc <= br_target;
				end
			end
		end
	end

	// fetch stage: word captured at phase four, dropped on a flush
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_word  <= 16'h0000;
			fetch_valid <= 1'b0;
		end else if (phase_four && !table_pending) begin
			fetch_word  <= prog_data;
			fetch_valid <= ~flush;
		end
	end

	// execute stage load
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			instruction_holding_register <= 16'h0000;
			ex_addr                      <= `CFP_RESET_PC;
			exec_valid                   <= 1'b0;
			second_valid                 <= 1'b0;
		end else if (phase_one) begin
			if (table_pending) begin
				exec_valid <= 1'b0;
			end else begin
				instruction_holding_register <= fetch_word;
				ex_addr                      <= fetch_addr;
				exec_valid                   <= fetch_valid;
				second_valid                 <= second_expected;
			end
		end
	end

	// a move or index first word that executed marks the next word as its literal
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			second_expected <= 1'b0;
			held_first      <= 16'h0000;
		end else if (phase_four) begin
			second_expected <= (op_ex == cfp_op_move) || (op_ex == cfp_op_index);
			if (op_ex == cfp_op_move || op_ex == cfp_op_index) begin
				held_first <= instruction_holding_register;
			end
		end
	end

	// data memory: read strobe in phase two, write strobe in phase four
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_rd    <= 1'b0;
			data_wr    <= 1'b0;
			data_addr  <= 12'h000;
			data_wdata <= 8'h00;
			operand    <= 8'h00;
		end else begin
			if (phase_one) begin
				data_rd <= load_reads;
				if (load_reads) begin
					data_addr <= load_addr;
				end
			end
			if (phase_two) begin
				data_rd <= 1'b0;
				if (data_rd) begin
					operand <= data_rdata;
				end
			end
			if (phase_three) begin
				if (op_ex == cfp_op_add_file &&
				    instruction_holding_register[7:0] != `CFP_PC_LOW_ADDR) begin
					data_wr    <= 1'b1;
					data_addr  <= {`CFP_FILE_BANK, instruction_holding_register[7:0]};
					data_wdata <= operand + working_register;
				end else if (move_second) begin
					data_wr    <= 1'b1;
					data_addr  <= instruction_holding_register[11:0];
					data_wdata <= operand;
				end
			end
			if (phase_four) begin
				data_wr <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			working_register <= 8'h00;
		end else if (phase_four) begin
			if (op_ex == cfp_op_add_w) begin
				working_register <= operand + working_register;
			end else if (op_ex == cfp_op_ret_lit || op_ex == cfp_op_load_w) begin
				working_register <= instruction_holding_register[7:0];
			end
		end
	end

	// index increments on push, saturating so the last entry is never overwritten
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			return_stack_index <= '0;
		end else if (phase_four) begin
			if (stack_we) begin
				return_stack_index <= return_stack_index + 1'b1;
			end else if (pop && return_stack_index != '0) begin
				return_stack_index <= return_stack_index - 1'b1;
			end
		end
	end

	// table read borrows the next fetch slot; the prefetched word is held
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			table_byte_pointer <= `CFP_RESET_PC;
			table_data_latch   <= 8'h00;
			table_pending      <= 1'b0;
			table_post_inc     <= 1'b0;
		end else if (phase_four) begin
			if (table_pending) begin
				table_data_latch <= table_byte_pointer[0] ? prog_data[15:8]
				                                          : prog_data[7:0];
				table_pending    <= 1'b0;
				if (table_post_inc) begin
					table_byte_pointer <= table_byte_pointer + 1'b1;
				end
			end else if (op_ex == cfp_op_table_rd || op_ex == cfp_op_table_inc) begin
				table_pending  <= 1'b1;
				table_post_inc <= (op_ex == cfp_op_table_inc);
			end else if (op_ex == cfp_op_tptr_lo) begin
				table_byte_pointer[7:0] <= instruction_holding_register[7:0];
			end else if (op_ex == cfp_op_tptr_hi) begin
				table_byte_pointer[15:8] <= instruction_holding_register[7:0];
			end else if (op_ex == cfp_op_tptr_up) begin
				table_byte_pointer[20:16] <= instruction_holding_register[4:0];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `CFP_INDEX_COUNT; g++) begin : gen_index
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					index_pointer[g*12 +: 12] <= 12'h000;
				end else if (phase_four && op_ex == cfp_op_second &&
				             held_first[15:8] == `CFP_OPC_INDEX &&
				             held_first[5:4] == 2'(g)) begin
					index_pointer[g*12 +: 12] <= {held_first[3:0],
					                             instruction_holding_register[7:0]};
				end
			end
		end
	endgenerate
endmodule

// file: rtl/cfp_phase_gen.sv
// Purpose: four one-hot phase strobes from the input clock
// Assumes: single clock domain
// Notes: strobes are enables, not derived clocks, to keep one domain
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_phase_gen (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	output logic [`CFP_PHASES-1:0]      phase
);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= `CFP_PHASE_RESET;
		end else begin
			phase <= {phase[`CFP_PHASES-2:0], phase[`CFP_PHASES-1]};
		end
	end
endmodule

// file: rtl/cfp_pkg.sv
// Purpose: shared types of the fetch and pipeline core
// Assumes: nothing
// Notes: operation classes after decode
package cfp_pkg;
	typedef enum logic [4:0] {
		cfp_op_nop,
		cfp_op_goto,
		cfp_op_call,
		cfp_op_branch,
		cfp_op_move,
		cfp_op_index,
		cfp_op_second,
		cfp_op_add_file,
		cfp_op_add_w,
		cfp_op_ret_lit,
		cfp_op_return,
		cfp_op_load_w,
		cfp_op_test_skip,
		cfp_op_table_rd,
		cfp_op_table_inc,
		cfp_op_tptr_lo,
		cfp_op_tptr_hi,
		cfp_op_tptr_up
	} cfp_op_t;
endpackage

// file: rtl/cfp_regs.svh
// Purpose: encodings, reset values and sizes of the fetch and pipeline core
// Assumes: included by bare name from every design file that needs it
// Notes: opcode encodings are local to this core
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH

`define CFP_PHASES         4
`define CFP_PHASE_RESET    4'h1
`define CFP_PC_W           21
`define CFP_RESET_PC       21'h000000
`define CFP_PC_STEP        21'h000002
`define CFP_FILE_BANK      4'hf
`define CFP_PC_LOW_ADDR    8'hf9
`define CFP_STACK_DEPTH    31
`define CFP_STACK_IDX_W    5
`define CFP_INDEX_COUNT    3

`define CFP_NIB_SECOND     4'hf
`define CFP_NIB_BRANCH     4'hd
`define CFP_NIB_MOVE       4'hc
`define CFP_OPC_GOTO       8'hef
`define CFP_OPC_CALL       8'hec
`define CFP_OPC_INDEX      8'hee
`define CFP_OPC_ADD_FILE   8'h26
`define CFP_OPC_ADD_W      8'h24
`define CFP_OPC_RET_LIT    8'h0c
`define CFP_OPC_LOAD_W     8'h0e
`define CFP_OPC_TEST_SKIP  8'h66
`define CFP_OPC_TPTR_LO    8'h0a
`define CFP_OPC_TPTR_HI    8'h0b
`define CFP_OPC_TPTR_UP    8'h0d
`define CFP_WORD_RETURN    16'h0012
`define CFP_WORD_TABLE_RD  16'h0008
`define CFP_WORD_TABLE_INC 16'h0009

`endif

// file: rtl/cfp_return_stack.sv
// Purpose: return address storage with registered read data
// Assumes: index 0 has no storage
// Notes: reading index 0 yields zero, which sends an underflowing return to zero
`timescale 1ns/1ns
module cfp_return_stack #(
	parameter int DEPTH = 31,
	parameter int IDX_W = 5,
	parameter int W     = 21
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             write_en,
	input  wire logic [IDX_W-1:0] write_idx,
	input  wire logic [W-1:0]     write_data,
	input  wire logic [IDX_W-1:0] read_idx,
	output logic      [W-1:0]     read_data
);
	logic [W-1:0] mem [1:DEPTH];

	always_ff @(posedge ref_clk) begin
		if (write_en && write_idx != '0) begin
			mem[write_idx] <= write_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= '0;
		end else if (read_idx == '0) begin
			read_data <= '0;
		end else begin
			read_data <= mem[read_idx];
		end
	end
endmodule

// file: sim/cfp_core_fetch_chk.sv
// Purpose: port-level timing checks of the fetch and pipeline core
// Assumes: bound to cfp_core_fetch, one clock domain
// Notes: opcode fields are taken from the holding register
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_core_fetch_chk #(
	parameter int STACK_DEPTH = 31,
	parameter int STACK_IDX_W = 5
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic [`CFP_PC_W-1:0]   prog_addr,
	input  wire logic                   prog_rd,
	input  wire logic [15:0]            prog_data,
	input  wire logic                   data_rd,
	input  wire logic                   data_wr,
	input  wire logic [`CFP_PHASES-1:0] phase,
	input  wire logic [15:0]            instruction_holding_register,
	input  wire logic                   exec_valid,
	input  wire logic [7:0]             working_register,
	input  wire logic [STACK_IDX_W-1:0] return_stack_index
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] opc;
	logic [7:0] lit;
	logic       last_q;
	logic       jump;
	assign opc    = instruction_holding_register[15:8];
	assign lit    = instruction_holding_register[7:0];
	assign last_q = phase[3] && exec_valid;
	// branch decision is taken at the last phase with the second word in view
	assign jump   = ((opc == `CFP_OPC_GOTO || opc == `CFP_OPC_CALL)
		&& prog_data[15:12] == `CFP_NIB_SECOND)
		|| instruction_holding_register[15:12] == `CFP_NIB_BRANCH;
	sequence s_rotate;
		phase[1] ##1 phase[2] ##1 phase[3] ##1 phase[0];
	endsequence
	sequence s_flush;
		##2 !exec_valid ##4 exec_valid;
	endsequence
	a_phase_onehot: assert property ($onehot(phase))
		else $error("phase strobes not one-hot");
	a_phase_order: assert property (phase[0] |=> s_rotate)
		else $error("phase strobes out of order");
	a_addr_hold: assert property (!$past(phase[0]) |-> $stable(prog_addr))
		else $error("program address moved outside phase one");
	a_seq_step: assert property (last_q && opc == `CFP_OPC_LOAD_W |->
		##2 prog_addr == $past(prog_addr, 2) + `CFP_PC_STEP)
		else $error("sequential fetch did not step by two");
	a_lit_to_w: assert property (last_q && opc == `CFP_OPC_LOAD_W |->
		##2 working_register == $past(lit, 2))
		else $error("literal not loaded into working register");
	a_read_phase_two: assert property (data_rd |-> phase[1])
		else $error("data read outside phase two");
	a_write_phase_four: assert property (data_wr |-> phase[3])
		else $error("data write outside phase four");
	a_fetch_level: assert property (prog_rd != phase[0])
		else $error("program read strobe wrong for phase");
	a_jump_flush: assert property (last_q && jump |-> s_flush)
		else $error("changed program counter did not flush one word");
	a_stack_step: assert property ($changed(return_stack_index) |->
		return_stack_index == $past(return_stack_index) + 1'b1
		|| return_stack_index == $past(return_stack_index) - 1'b1)
		else $error("stack index moved by more than one");
	// a full stack must saturate, a wrap to zero would lose every return address
	a_stack_range: assert property ($past(return_stack_index) == STACK_DEPTH |->
		return_stack_index != '0)
		else $error("stack index wrapped past full");
endmodule

bind cfp_core_fetch cfp_core_fetch_chk #(.STACK_DEPTH(STACK_DEPTH), .STACK_IDX_W(STACK_IDX_W))
	i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_rd(prog_rd),
	.prog_data(prog_data), .data_rd(data_rd), .data_wr(data_wr), .phase(phase),
	.instruction_holding_register(instruction_holding_register), .exec_valid(exec_valid),
	.working_register(working_register), .return_stack_index(return_stack_index));

// file: sim/cfp_mem_model.sv
// Purpose: program and data memory on the far side of the fetch core
// Assumes: contents loaded by the bench through rom and ram
// Notes: a released read line shows the inverse of its last value
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_mem_model (
	input  wire logic                 ref_clk,
	input  wire logic [`CFP_PC_W-1:0] prog_addr,
	input  wire logic                 prog_rd,
	output logic      [15:0]          prog_data,
	input  wire logic [11:0]          data_addr,
	input  wire logic                 data_rd,
	input  wire logic                 data_wr,
	input  wire logic [7:0]           data_wdata,
	output logic      [7:0]           data_rdata
);
	logic [15:0] rom [0:1023];
	logic [7:0]  ram [0:4095];
	logic [15:0] last_word;
	logic [7:0]  last_byte;
	// whole word for any byte address, the core picks the byte itself
	assign prog_data  = prog_rd ? rom[prog_addr[10:1]] : ~last_word;
	assign data_rdata = data_rd ? ram[data_addr] : ~last_byte;
	always @(posedge ref_clk) begin
		if (prog_rd) last_word <= prog_data;
		if (data_rd) last_byte <= data_rdata;
		if (data_wr) ram[data_addr] <= data_wdata;
	end
endmodule

// file: sim/core_fetch_pipeline_tb.sv
// Purpose: self-checking bench of the fetch and pipeline core
// Assumes: program image is loaded while reset is held
// Notes: every test restarts the core with its own program
`timescale 1ns/1ns
`include "cfp_regs.svh"
module core_fetch_pipeline_tb;
	logic                           ref_clk;
	logic                           rst_n;
	logic [`CFP_PC_W-1:0]           prog_addr;
	logic                           prog_rd;
	logic [15:0]                    prog_data;
	logic [11:0]                    data_addr;
	logic                           data_rd;
	logic                           data_wr;
	logic [7:0]                     data_wdata;
	logic [7:0]                     data_rdata;
	logic [`CFP_PHASES-1:0]         phase;
	logic [15:0]                    insn;
	logic                           exec_valid;
	logic [7:0]                     w;
	logic [`CFP_PC_W-1:0]           tptr;
	logic [7:0]                     tlat;
	logic [12*`CFP_INDEX_COUNT-1:0] idx_ptr;
	logic [4:0]                     sidx;
	int                             err_total;
	int                             checks;

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	cfp_core_fetch i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .prog_addr(prog_addr),
		.prog_rd(prog_rd), .prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd),
		.data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata), .phase(phase),
		.instruction_holding_register(insn), .exec_valid(exec_valid), .working_register(w),
		.table_byte_pointer(tptr), .table_data_latch(tlat), .index_pointer(idx_ptr),
		.return_stack_index(sidx));
	cfp_mem_model i_mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
		.data_wdata(data_wdata), .data_rdata(data_rdata));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// reset lands mid-run on purpose, the core must come back clean
	task automatic hold;
		@(posedge ref_clk);
		#5 rst_n = 1'b0;
		for (int i = 0; i < 1024; i++) i_mem.rom[i] = 16'h0000;
	endtask

	task automatic go(input int n);
		repeat (20) @(posedge ref_clk);
		#5 rst_n = 1'b1;
		repeat (4 * n) @(posedge ref_clk);
		#5;
	endtask

	task automatic t_reset_pipe;
		hold();
		i_mem.rom[0] = 16'h0e5a;
		i_mem.rom[1] = 16'h0e33;
		repeat (20) @(posedge ref_clk);
		check("phase", phase, `CFP_PHASE_RESET);
		check("valid", exec_valid, 1'b0);
		#5 rst_n = 1'b1;
		@(posedge ref_clk);
		#5;
		check("addr", prog_addr, 32'h0);
		check("valid", exec_valid, 1'b0);
		for (int i = 1; i <= 3; i++) begin
			repeat (4) @(posedge ref_clk);
			#5;
			check("addr", prog_addr, 2 * i);
			check("valid", exec_valid, 1'b1);
			if (i == 1) check("insn", insn, 16'h0e5a);
		end
		check("w", w, 8'h33);
		$display("test reset_pipe done");
	endtask

	task automatic t_add_file;
		hold();
		i_mem.ram[12'hf10] = 8'h11;
		i_mem.rom[0] = 16'h0e05;
		i_mem.rom[1] = 16'h2610;
		i_mem.rom[2] = 16'h2410;
		i_mem.rom[3] = 16'hee1a;
		i_mem.rom[4] = 16'hf0bc;
		go(7);
		check("ram", i_mem.ram[12'hf10], 8'h16);
		check("w", w, 8'h1b);
		check("index", idx_ptr[31:0], 32'h00abc000);
		$display("test add_file done");
	endtask

	task automatic t_goto;
		hold();
		i_mem.ram[12'hf20] = 8'h00;
		i_mem.rom[0] = 16'h0e01;
		i_mem.rom[1] = 16'hef40;
		i_mem.rom[2] = 16'hf000;
		i_mem.rom[3] = 16'h2620;
		i_mem.rom[12'h040] = 16'h0e77;
		go(7);
		check("ram", i_mem.ram[12'hf20], 8'h00);
		check("w", w, 8'h77);
		$display("test goto done");
	endtask

	task automatic t_branch;
		hold();
		i_mem.rom[0] = 16'hd003;
		i_mem.rom[1] = 16'h0e66;
		i_mem.rom[2] = 16'hd004;
		i_mem.rom[3] = 16'h0e11;
		i_mem.rom[4] = 16'h0e44;
		i_mem.rom[5] = 16'hd7fb;
		i_mem.rom[6] = 16'h0e11;
		go(14);
		check("w", w, 8'h66);
		$display("test branch done");
	endtask

	task automatic t_skip;
		hold();
		i_mem.ram[12'hf30] = 8'h00;
		i_mem.ram[12'hf31] = 8'h01;
		i_mem.ram[12'h040] = 8'h5c;
		i_mem.ram[12'h050] = 8'h00;
		i_mem.ram[12'h051] = 8'h00;
		i_mem.rom[0] = 16'h6630;
		i_mem.rom[1] = 16'hc040;
		i_mem.rom[2] = 16'hf050;
		i_mem.rom[3] = 16'h6631;
		i_mem.rom[4] = 16'hc040;
		i_mem.rom[5] = 16'hf051;
		i_mem.rom[6] = 16'h0e88;
		go(12);
		check("ram", i_mem.ram[12'h050], 8'h00);
		check("ram", i_mem.ram[12'h051], 8'h5c);
		check("w", w, 8'h88);
		$display("test skip done");
	endtask

	task automatic t_computed;
		hold();
		i_mem.ram[12'hf40] = 8'h00;
		i_mem.rom[0] = 16'h0e04;
		i_mem.rom[1] = 16'hec20;
		i_mem.rom[2] = 16'hf000;
		i_mem.rom[3] = 16'h2640;
		i_mem.rom[4] = 16'hec30;
		i_mem.rom[5] = 16'hf000;
		i_mem.rom[6] = 16'h2640;
		i_mem.rom[12'h030] = 16'h0012;
		i_mem.rom[12'h020] = 16'h26f9;
		for (int i = 1; i <= 4; i++) i_mem.rom[12'h020 + i] = 16'h0ca0 + i[15:0];
		go(5);
		check("sidx", sidx, 5'd1);
		repeat (48) @(posedge ref_clk);
		#5;
		check("ram", i_mem.ram[12'hf40], 8'h46);
		check("w", w, 8'ha3);
		check("sidx", sidx, 5'd0);
		$display("test computed done");
	endtask

	task automatic t_table;
		logic [7:0] prev;
		logic [7:0] seen [$];
		hold();
		i_mem.rom[0] = 16'h0a81;
		i_mem.rom[1] = 16'h0b00;
		i_mem.rom[2] = 16'h0d00;
		i_mem.rom[3] = 16'h0009;
		i_mem.rom[4] = 16'h0009;
		i_mem.rom[5] = 16'h0008;
		i_mem.rom[12'h040] = 16'h5a3c;
		i_mem.rom[12'h041] = 16'hc6e7;
		prev = 8'h00;
		go(0);
		repeat (64) begin
			@(posedge ref_clk);
			#5;
			if (tlat !== prev) seen.push_back(tlat);
			prev = tlat;
		end
		check("count", seen.size(), 32'd3);
		check("byte", seen[0], 8'h5a);
		check("byte", seen[1], 8'he7);
		check("byte", seen[2], 8'hc6);
		check("tptr", tptr, 21'h000083);
		$display("test table done");
	endtask

	initial begin
		rst_n = 1'b0;
		err_total = 0;
		checks = 0;
		t_reset_pipe();
		t_add_file();
		t_goto();
		t_branch();
		t_skip();
		t_computed();
		t_table();
		test_done();
	end

	initial begin
		repeat (8000) @(posedge ref_clk);
		err_total++;
		test_done();
	end
endmodule
